// ### inc/rss_cfg.svh
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// ****************************************
// Register subaddresses
// ****************************************
`define RSS_ADDR_GAP_A 8'h20
`define RSS_ADDR_GAP_B 8'h21
`define RSS_ADDR_MAP_A 8'h22
`define RSS_ADDR_MAP_B 8'h23
`define RSS_ADDR_BACKUP 8'h24
`define RSS_ADDR_SWITCH 8'h25
`define RSS_REG_COUNT 6

// ****************************************
// Reset values and writable-bit masks
// ****************************************
`define RSS_RST_GAP_A 8'h00
`define RSS_RST_GAP_B 8'h00
`define RSS_RST_MAP_A 8'h98
`define RSS_RST_MAP_B 8'h75
`define RSS_RST_BACKUP 8'h12
`define RSS_RST_SWITCH 8'h63
`define RSS_MASK_GAP_B 8'h81
`define RSS_MASK_BACKUP 8'h33
`define RSS_MASK_FULL 8'hff

// ****************************************
// Field positions
// ****************************************
`define RSS_FACTOR_BIT 7
`define RSS_GAP_NINE_BIT 0
`define RSS_HI_LSB 4
`define RSS_LO_LSB 0

// ****************************************
// Strobe codes and timing
// ****************************************
`define RSS_MAIN_FIRST 4'h3
`define RSS_MAIN_LAST 4'ha
`define RSS_BACKUP_FIRST 4'h1
`define RSS_BACKUP_LAST 4'h2
`define RSS_STEP_FIRST 4'h1
`define RSS_STEP_LAST 4'ha
`define RSS_CLK_MHZ 25
`define RSS_GAP_SHORT_US 2000
`define RSS_GAP_LONG_US 5000
`define RSS_DOWN_FACTOR 10
`define RSS_GAP_SHORT_CYC (`RSS_GAP_SHORT_US * `RSS_CLK_MHZ)
`define RSS_GAP_LONG_CYC (`RSS_GAP_LONG_US * `RSS_CLK_MHZ)
`define RSS_LOAD_START 4'h2
`define RSS_LOAD_END 4'h8

`endif

// ### inc/rss_pkg.sv
package rss_pkg;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_LOAD = 5'b00001,
        ST_OFF = 5'b00010,
        ST_STEP = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_ON = 5'b10000
    } rss_state_t;

    // Register port request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } rss_req_t;

    // Sequencer control inputs
    typedef struct packed {
        logic powerUpReq;
        logic powerDownReq;
        logic sealFlag;
    } rss_ctl_t;

    // All state of the top module
    typedef struct packed {
        rss_state_t st;
        logic [3:0] loadCnt;
        logic [5:0][7:0] regs;
        logic armed;
        logic powerDown;
        logic [3:0] step;
        logic [23:0] timer;
        logic [5:0] railEn;
        logic [7:0] rdData;
        logic blankMeta;
        logic blankSync;
    } rss_core_t;

    // All state of the store
    typedef struct packed {
        logic [5:0][7:0] mem;
        logic [7:0] rdData;
    } rss_store_t;

endpackage : rss_pkg

// ### verilog/rss_store.sv
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_store (
    // Clock
    input wire logic mclk,
    // Control
    input wire logic initStore,
    // Write port
    input wire logic wrEn,
    input wire logic [2:0] wrAddr,
    input wire logic [7:0] wrData,
    // Read port
    input wire logic [2:0] rdAddr,
    output logic [7:0] rdData
);

    localparam logic [5:0][7:0] DEFAULTS = {`RSS_RST_SWITCH, `RSS_RST_BACKUP, `RSS_RST_MAP_B,
                                           `RSS_RST_MAP_A, `RSS_RST_GAP_B, `RSS_RST_GAP_A};

    rss_pkg::rss_store_t cur_ff;
    rss_pkg::rss_store_t nxt_cur;

    // Contents survive rst_n; only a blank-store request restores defaults
    always_comb begin
        nxt_cur = cur_ff;
        if (initStore) begin
            nxt_cur.mem = DEFAULTS;
        end else if (wrEn && wrAddr < 3'(`RSS_REG_COUNT)) begin
            nxt_cur.mem[wrAddr] = wrData;
        end
        if (rdAddr < 3'(`RSS_REG_COUNT)) begin
            nxt_cur.rdData = initStore ? DEFAULTS[rdAddr] : cur_ff.mem[rdAddr];
        end else begin
            nxt_cur.rdData = 8'h00;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        cur_ff <= nxt_cur;
    end

    assign rdData = cur_ff.rdData;

endmodule : rss_store

// ### verilog/rss_seq.sv
// Overview of operation
// - Four-bit codes 3h..Ah enable the rail at strobe step three..ten.
// - Four-bit codes 0h..2h and Bh..Fh leave the rail uncontrolled.
// - Buck one field is bits 3..0 of map A, reset 8h.
// - Map B holds buck-boost in bits 7..4, buck three in 3..0.
// - Map B resets to 75h.
// - Backup map: io field bits 5..4, core bits 1..0, rest read zero.
// - Two-bit codes 1h,2h enable at strobe one,two; 0h,3h uncontrolled.
// - Backup map resets to 12h.
// - Strobe steps one and two run only while the seal flag is zero.
// - With the seal broken, backup converters are never switched off.
// - Switch map holds the low-voltage switch field in bits 7..4.
// - Switch map resets to 63h.
// - Each gap waits 2 ms, or 5 ms when its delay bit is set.
// - Delay factor bit stretches gaps tenfold, during power-down only.
// - Map A sits at subaddress 22h.
`timescale 1ns/1ps
`include "rss_cfg.svh"

module rss_seq #(
    parameter int GAP_SHORT_CYC = `RSS_GAP_SHORT_CYC,
    parameter int GAP_LONG_CYC = `RSS_GAP_LONG_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input rss_pkg::rss_req_t req,
    input wire logic unlockPulse,
    output logic [7:0] regRdData,
    output logic loadBusy,
    // Sequencer control
    input rss_pkg::rss_ctl_t ctl,
    input wire logic storeBlankPin,
    // Sequencer results
    output logic [5:0] railEn,
    output logic [3:0] strobeStep,
    output logic seqBusy
);

    // ****************************************
    // Declarations
    // ****************************************
    rss_pkg::rss_core_t cur_ff;
    rss_pkg::rss_core_t nxt_cur;
    logic [7:0] storeRdData;
    logic [2:0] storeRdAddr;
    logic storeWrEn;
    logic [2:0] regIdx;
    logic regHit;
    logic [7:0] regMask;
    logic [5:0] railHit;
    logic [5:0] railCode [6];
    logic [8:0] gapSel;
    logic [3:0] gapIdx;
    logic [23:0] gapCycles;
    logic lastStep;
    logic skipStep;

    // ****************************************
    // Address decode
    // ****************************************
    // subaddress decode for all six registers
    always_comb begin
        regHit = 1'b1;
        regIdx = 3'd0;
        regMask = `RSS_MASK_FULL;
        case (req.addr)
            `RSS_ADDR_GAP_A: regIdx = 3'd0;
            `RSS_ADDR_GAP_B: begin
                regIdx = 3'd1;
                regMask = `RSS_MASK_GAP_B;
            end
            `RSS_ADDR_MAP_A: regIdx = 3'd2;
            `RSS_ADDR_MAP_B: regIdx = 3'd3;
            `RSS_ADDR_BACKUP: begin
                regIdx = 3'd4;
                regMask = `RSS_MASK_BACKUP;
            end
            `RSS_ADDR_SWITCH: regIdx = 3'd5;
            default: regHit = 1'b0;
        endcase
    end

    // Write reaches the store only when unlocked and not reloading
    // password gate
    assign storeWrEn = req.wrEn && regHit && cur_ff.armed && cur_ff.st != rss_pkg::ST_LOAD;

    // ****************************************
    // Rail fields
    // ****************************************
    // buck one field
    assign railCode[0] = {2'b00, cur_ff.regs[2][`RSS_LO_LSB +: 4]};
    assign railCode[1] = {2'b00, cur_ff.regs[3][`RSS_LO_LSB +: 4]};
    assign railCode[2] = {2'b00, cur_ff.regs[3][`RSS_HI_LSB +: 4]};
    assign railCode[3] = {4'h0, cur_ff.regs[4][`RSS_LO_LSB +: 2]};
    assign railCode[4] = {4'h0, cur_ff.regs[4][`RSS_HI_LSB +: 2]};
    assign railCode[5] = {2'b00, cur_ff.regs[5][`RSS_HI_LSB +: 4]};

    // Per-rail match of its field against the running strobe step
    for (genvar i = 0; i < 6; i++) begin : g_rail
        if (i == 3 || i == 4) begin : g_backup
            assign railHit[i] = railCode[i][3:0] >= `RSS_BACKUP_FIRST && railCode[i][3:0] <= `RSS_BACKUP_LAST
                                && railCode[i][3:0] == cur_ff.step;
        end else begin : g_main
            assign railHit[i] = railCode[i][3:0] >= `RSS_MAIN_FIRST && railCode[i][3:0] <= `RSS_MAIN_LAST
                                && railCode[i][3:0] == cur_ff.step;
        end
    end

    // ****************************************
    // Gap timing
    // ****************************************
    assign gapSel = {cur_ff.regs[1][`RSS_GAP_NINE_BIT], cur_ff.regs[0]};
    // Gap k follows strobe k; going down the gap below the step is used
    assign gapIdx = cur_ff.powerDown ? cur_ff.step - 4'd2 : cur_ff.step - 4'd1;

    always_comb begin
        gapCycles = gapSel[gapIdx] ? 24'(GAP_LONG_CYC) : 24'(GAP_SHORT_CYC);
        if (cur_ff.powerDown && cur_ff.regs[1][`RSS_FACTOR_BIT]) begin
            gapCycles = gapSel[gapIdx] ? 24'(GAP_LONG_CYC * `RSS_DOWN_FACTOR)
                                       : 24'(GAP_SHORT_CYC * `RSS_DOWN_FACTOR);
        end
    end

    assign lastStep = cur_ff.powerDown ? cur_ff.step == `RSS_STEP_FIRST : cur_ff.step == `RSS_STEP_LAST;
    assign skipStep = ctl.sealFlag && cur_ff.step <= `RSS_BACKUP_LAST;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_cur = cur_ff;
        // Blank-store pin is asynchronous, two flops before use
        nxt_cur.blankMeta = storeBlankPin;
        nxt_cur.blankSync = cur_ff.blankMeta;

        // Unlock arms one write; a fresh unlock wins over the consuming write
        // unlock arming
        if (req.wrEn) begin
            nxt_cur.armed = 1'b0;
        end
        if (unlockPulse) begin
            nxt_cur.armed = 1'b1;
        end

        // Register write and read-back
        if (storeWrEn) begin
            nxt_cur.regs[regIdx] = req.wrData & regMask;
        end
        if (req.rdEn) begin
            nxt_cur.rdData = regHit ? cur_ff.regs[regIdx] & regMask : 8'h00;
        end

        case (cur_ff.st)
            rss_pkg::ST_LOAD: begin
                nxt_cur.loadCnt = cur_ff.loadCnt + 4'd1;
                if (cur_ff.loadCnt > `RSS_LOAD_START) begin
                    nxt_cur.regs[3'(cur_ff.loadCnt - `RSS_LOAD_START - 4'd1)] = storeRdData
                        & (cur_ff.loadCnt == 4'd4 ? `RSS_MASK_GAP_B
                        : cur_ff.loadCnt == 4'd7 ? `RSS_MASK_BACKUP : `RSS_MASK_FULL);
                end
                if (cur_ff.loadCnt == `RSS_LOAD_END) begin
                    nxt_cur.st = rss_pkg::ST_OFF;
                end
            end
            rss_pkg::ST_OFF: begin
                if (ctl.powerUpReq) begin
                    nxt_cur.powerDown = 1'b0;
                    nxt_cur.step = `RSS_STEP_FIRST;
                    nxt_cur.st = rss_pkg::ST_STEP;
                end
            end
            rss_pkg::ST_ON: begin
                if (ctl.powerDownReq) begin
                    nxt_cur.powerDown = 1'b1;
                    nxt_cur.step = `RSS_STEP_LAST;
                    nxt_cur.st = rss_pkg::ST_STEP;
                end
            end
            rss_pkg::ST_STEP: begin
                if (!skipStep) begin
                    if (cur_ff.powerDown) begin
                        nxt_cur.railEn = cur_ff.railEn & ~(railHit & (ctl.sealFlag ? 6'h27 : 6'h3f));
                    end else begin
                        nxt_cur.railEn = cur_ff.railEn | railHit;
                    end
                end
                if (lastStep) begin
                    nxt_cur.st = cur_ff.powerDown ? rss_pkg::ST_OFF : rss_pkg::ST_ON;
                end else if (skipStep) begin
                    // Skipped steps cost no gap
                    nxt_cur.step = cur_ff.powerDown ? cur_ff.step - 4'd1 : cur_ff.step + 4'd1;
                end else begin
                    nxt_cur.timer = gapCycles;
                    nxt_cur.st = rss_pkg::ST_WAIT;
                end
            end
            rss_pkg::ST_WAIT: begin
                nxt_cur.timer = cur_ff.timer - 24'd1;
                if (cur_ff.timer <= 24'd1) begin
                    nxt_cur.step = cur_ff.powerDown ? cur_ff.step - 4'd1 : cur_ff.step + 4'd1;
                    nxt_cur.st = rss_pkg::ST_STEP;
                end
            end
            default: nxt_cur.st = rss_pkg::ST_OFF;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    // reset values
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur_ff <= '0;
            cur_ff.st <= rss_pkg::ST_LOAD;
            cur_ff.regs <= {`RSS_RST_SWITCH, `RSS_RST_BACKUP, `RSS_RST_MAP_B,
                            `RSS_RST_MAP_A, `RSS_RST_GAP_B, `RSS_RST_GAP_A};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ****************************************
    // Store
    // ****************************************
    // Read address runs two counts behind so the blank pin is settled first
    assign storeRdAddr = (cur_ff.loadCnt >= `RSS_LOAD_START) ? 3'(cur_ff.loadCnt - `RSS_LOAD_START) : 3'd7;

    rss_store rss_store_inst (
        .mclk(mclk),
        .initStore(cur_ff.blankSync),
        .wrEn(storeWrEn),
        .wrAddr(regIdx),
        .wrData(req.wrData & regMask),
        .rdAddr(storeRdAddr),
        .rdData(storeRdData)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign regRdData = cur_ff.rdData;
    assign railEn = cur_ff.railEn;
    assign strobeStep = cur_ff.step;
    assign seqBusy = cur_ff.st == rss_pkg::ST_STEP || cur_ff.st == rss_pkg::ST_WAIT;
    assign loadBusy = cur_ff.st == rss_pkg::ST_LOAD;

endmodule : rss_seq

// ### tb/rss_seq_sva.sv
`timescale 1ns/1ps
module rss_seq_sva #(
    parameter int GAP_SHORT_CYC = 50000,
    parameter int GAP_LONG_CYC = 125000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire rss_pkg::rss_req_t req,
    input wire logic unlockPulse,
    input wire logic [7:0] regRdData,
    input wire logic loadBusy,
    // Sequencer
    input wire rss_pkg::rss_ctl_t ctl,
    input wire logic storeBlankPin,
    input wire logic [5:0] railEn,
    input wire logic [3:0] strobeStep,
    input wire logic seqBusy
);
    // ****************************************
    // Step hold counter
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [3:0] prevStep_ff;
    logic [31:0] holdCnt_ff;
    // Edges the step value has held; one step plus its gap shows as N+1
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prevStep_ff <= 4'h0;
            holdCnt_ff <= 32'h0;
        end else begin
            prevStep_ff <= strobeStep;
            holdCnt_ff <= (strobeStep != prevStep_ff) ? 32'h1 : holdCnt_ff + 32'h1;
        end
    end
    a_load_busy_len: assert property ($rose(rst_n) |-> loadBusy [*8])
        else $error("load window too short");
    a_load_quiet: assert property (loadBusy |-> !seqBusy && railEn == 6'h00)
        else $error("sequencer active during load");
    a_step_range: assert property (seqBusy |-> strobeStep >= 4'h1 && strobeStep <= 4'ha)
        else $error("strobe step out of range");
    a_backup_hold: assert property ($fell(railEn[3]) || $fell(railEn[4]) |-> !$past(ctl.sealFlag))
        else $error("backup rail cleared with seal broken");
    a_skip_steps: assert property (ctl.sealFlag && seqBusy && strobeStep <= 4'h2 |=> $stable(railEn))
        else $error("sealed early step changed a rail");
    a_idle_rails: assert property (!seqBusy && !loadBusy |=> $stable(railEn))
        else $error("rail changed outside a sequence");
    a_reserved_zero: assert property (req.rdEn && req.addr == 8'h24 |=> (regRdData & 8'hcc) == 8'h00)
        else $error("reserved bits read nonzero");
    a_unmapped_zero: assert property (req.rdEn && req.addr > 8'h25 |=> regRdData == 8'h00)
        else $error("unmapped read nonzero");
    // Step ten also counts its idle time in ON, so only gaps leaving steps 3..9 are timed
    a_gap_length: assert property (seqBusy && strobeStep != prevStep_ff && prevStep_ff >= 4'h3 && prevStep_ff <= 4'h9 |->
        holdCnt_ff >= GAP_SHORT_CYC + 1 && holdCnt_ff <= GAP_LONG_CYC * 10 + 1)
        else $error("gap length out of range");
    cover property (seqBusy && ctl.sealFlag && strobeStep == 4'h1);
    cover property ($fell(seqBusy));
    cover property (req.rdEn && req.addr == 8'h24);
endmodule : rss_seq_sva

bind rss_seq rss_seq_sva #(.GAP_SHORT_CYC(GAP_SHORT_CYC), .GAP_LONG_CYC(GAP_LONG_CYC)) rss_seq_sva_inst (
    .mclk(mclk), .rst_n(rst_n), .req(req), .unlockPulse(unlockPulse), .regRdData(regRdData),
    .loadBusy(loadBusy), .ctl(ctl), .storeBlankPin(storeBlankPin), .railEn(railEn),
    .strobeStep(strobeStep), .seqBusy(seqBusy));

// ### tb/tb_rss_seq.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_rss_seq;
    // ****************************************
    // Bench signals
    // ****************************************
    // Short gaps keep whole sequences to a few hundred cycles
    localparam int GAP_S = 4;
    localparam int GAP_L = 7;
    logic mclk;
    logic rst_n;
    rss_pkg::rss_req_t req;
    rss_pkg::rss_ctl_t ctl;
    logic unlockPulse;
    logic storeBlankPin;
    logic [7:0] regRdData;
    logic loadBusy;
    logic [5:0] railEn;
    logic [3:0] strobeStep;
    logic seqBusy;
    int fails;
    int check_count;
    int busyCnt;
    logic [3:0] riseStep [6];
    rss_seq #(.GAP_SHORT_CYC(GAP_S), .GAP_LONG_CYC(GAP_L)) rss_seq_inst (.mclk(mclk), .rst_n(rst_n),
        .req(req), .unlockPulse(unlockPulse), .regRdData(regRdData), .loadBusy(loadBusy), .ctl(ctl),
        .storeBlankPin(storeBlankPin), .railEn(railEn), .strobeStep(strobeStep), .seqBusy(seqBusy));
    // Free running clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit unl);
        if (unl) begin
            unlockPulse = 1'b1;
            tick();
            unlockPulse = 1'b0;
        end
        req.wrEn = 1'b1;
        req.addr = a;
        req.wrData = d;
        tick();
        req.wrEn = 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req.rdEn = 1'b1;
        req.addr = a;
        tick();
        req.rdEn = 1'b0;
        `CHK(regRdData, e)
        tick();
    endtask : rd
    // Store keeps its contents across reset, so blank only on first use
    task automatic doReset(input logic blank);
        rst_n = 1'b0;
        storeBlankPin = blank;
        repeat (8) tick();
        rst_n = 1'b1;
        for (int i = 0; i < 50 && loadBusy !== 1'b0; i++) tick();
        storeBlankPin = 1'b0;
        `CHK(loadBusy, 1'b0)
        tick();
    endtask : doReset
    // Request level is dropped once busy shows, else OFF would restart
    task automatic runSeq(input bit up, input int expCnt, input logic [5:0] expEn);
        logic [5:0] prev;
        busyCnt = 0;
        prev = railEn;
        foreach (riseStep[i]) riseStep[i] = 4'h0;
        if (up) ctl.powerUpReq = 1'b1;
        else ctl.powerDownReq = 1'b1;
        for (int n = 0; n < 2000; n++) begin
            tick();
            for (int i = 0; i < 6; i++) if (railEn[i] === 1'b1 && prev[i] === 1'b0) riseStep[i] = strobeStep;
            prev = railEn;
            if (seqBusy === 1'b1) begin
                busyCnt++;
                ctl.powerUpReq = 1'b0;
                ctl.powerDownReq = 1'b0;
            end else if (busyCnt > 0) break;
        end
        `CHK(railEn, expEn)
        if (expCnt > 0) `CHK(busyCnt, expCnt)
    endtask : runSeq
    task automatic results();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    // Hang guard, well past the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        results();
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        req = '0;
        ctl = '0;
        unlockPulse = 1'b0;
        storeBlankPin = 1'b1;
        fails = 0;
        check_count = 0;
        doReset(1'b1);
        rd(8'h20, 8'h00);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h98);
        rd(8'h23, 8'h75);
        rd(8'h24, 8'h12);
        rd(8'h25, 8'h63);
        rd(8'h30, 8'h00);
        $display("test reset values done");
        wr(8'h23, 8'ha3, 1'b0);
        rd(8'h23, 8'h75);
        wr(8'h23, 8'ha3, 1'b1);
        wr(8'h23, 8'h33, 1'b0);
        rd(8'h23, 8'ha3);
        wr(8'h24, 8'hff, 1'b1);
        rd(8'h24, 8'h33);
        wr(8'h24, 8'h21, 1'b1);
        wr(8'h22, 8'h0b, 1'b1);
        wr(8'h25, 8'h2f, 1'b1);
        rd(8'h25, 8'h2f);
        $display("test register access done");
        runSeq(1'b1, 10 + 9 * GAP_S, 6'h1e);
        `CHK(riseStep[0], 4'h0)
        `CHK(riseStep[5], 4'h0)
        `CHK(riseStep[1], 4'h3)
        `CHK(riseStep[2], 4'ha)
        `CHK(riseStep[3], 4'h1)
        `CHK(riseStep[4], 4'h2)
        $display("test power up done");
        // Reserved bits of the factor register must drop on the way in
        wr(8'h21, 8'hfe, 1'b1);
        rd(8'h21, 8'h80);
        runSeq(1'b0, 10 + 9 * GAP_S * 10, 6'h00);
        runSeq(1'b1, 10 + 9 * GAP_S, 6'h1e);
        ctl.sealFlag = 1'b1;
        // Steps two and one are skipped, so only eight gaps remain
        runSeq(1'b0, 10 + 8 * GAP_S * 10, 6'h18);
        $display("test power down done");
        doReset(1'b0);
        `CHK(railEn, 6'h00)
        rd(8'h23, 8'ha3);
        rd(8'h21, 8'h80);
        // Long gaps after steps 3..8, short after step 9
        wr(8'h20, 8'hff, 1'b1);
        runSeq(1'b1, 10 + 6 * GAP_L + GAP_S, 6'h06);
        `CHK(riseStep[3], 4'h0)
        `CHK(riseStep[4], 4'h0)
        `CHK(riseStep[1], 4'h3)
        `CHK(riseStep[2], 4'ha)
        $display("test reload and seal done");
        results();
    end
endmodule : tb_rss_seq
